// ---- rtl/see_top.sv ----
// Operation
// - Control byte is code, three select bits, R/W; acked on ninth clock.
// - Byte after acked write control byte loads the address pointer, acked.
// - One data byte then STOP starts the internal write cycle.
// - No acknowledge for any byte while a write cycle runs.
// - Write protected: still acknowledge everything but leave memory unchanged.
// - A write ending in STOP after at least one data byte always runs the full busy time.
// - Up to 15 more bytes held in page buffer, committed after STOP.
// - Each written data byte increments only the low four pointer bits.
// - Over sixteen bytes wrap the buffer; only the last sixteen are kept.
// - Page write wraps within its own aligned sixteen-byte page.
// - Protect input low allows writes to every location.
// - Polling control byte unacked while busy, acked once done.
// - Read control byte acked, then byte at current pointer is sent.
// - Master ends a read with no acknowledge and STOP; device stops.
// - Repeated START after address ends write without a cycle, keeps pointer.
// - After a random read the pointer holds the next location.
// - Master acknowledge in a read sends the next sequential byte.
// - Full pointer wraps from highest address to zero when reading.
// - Respond only to code 1010 with matching chip select levels.
// - On master no-acknowledge the data line is released high.
module see_top #(
    parameter int unsigned TWC_CYCLES = see_pkg::TWC_CYC
) (
    // System clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Link sampling clock
    input  wire logic lclk,
    // Serial bus, open drain data
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // Straps
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    input  wire logic wp,
    // Status
    output logic      write_busy
);

    localparam int unsigned AW = see_pkg::ADDR_W;
    localparam int unsigned PW = see_pkg::PAGE_W;
    localparam int unsigned PL = see_pkg::PAGE_LEN;
    localparam int unsigned DEPTH = 1 << AW;

    see_xif xif ();

    see_wtimer #(.TWC_CYCLES(TWC_CYCLES)) u_wtimer (
        .mclk (mclk),
        .rst  (rst),
        .xif  (xif)
    );

    assign write_busy = xif.busy;

    logic       lrst;
    logic [6:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] cs_s;
    logic       busy_s;

    see_sync #(.W(1)) u_rst (
        .clk (lclk),
        .d   (rst),
        .q   (lrst)
    );

    see_sync #(.W(7)) u_pins (
        .clk (lclk),
        .d   ({scl, sda_in, wp, chip_select_bit2, chip_select_bit1,
               chip_select_bit0, xif.busy}),
        .q   (pins_s)
    );

    assign {scl_s, sda_s, wp_s, cs_s, busy_s} = pins_s;

    see_pkg::see_state_t state;
    see_pkg::see_state_t next_state;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic [7:0]          shreg;
    logic [7:0]          next_shreg;
    logic [7:0]          rbyte;
    logic [7:0]          next_rbyte;
    logic [AW-1:0]       ptr;
    logic [AW-1:0]       next_ptr;
    logic                ack;
    logic                next_ack;
    logic                mack;
    logic                next_mack;
    logic                oe_n;
    logic                next_oe_n;
    logic                pend;
    logic                next_pend;
    logic                hold;
    logic                next_hold;
    logic                tgl;
    logic                next_tgl;
    logic [PL-1:0]       pvalid;
    logic [PL-1:0]       next_pvalid;
    logic [7:0]          pbuf [PL];
    logic [7:0]          next_pbuf [PL];
    logic [7:0]          mem [DEPTH];
    logic [7:0]          next_mem [DEPTH];
    logic                scl_d;
    logic                sda_d;

    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic gate;
    logic byte_ok;
    logic commit;

    assign rise  = scl_s & ~scl_d;
    assign fall  = ~scl_s & scl_d;
    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop  = scl_s & scl_d & ~sda_d & sda_s;
    // Hold covers the gap before the busy level has crossed back
    assign gate  = busy_s | hold;

    always_comb begin
        if (state == see_pkg::S_CTRL) begin
            byte_ok = (shreg[see_pkg::CODE_HI:see_pkg::CODE_LO]
                       == see_pkg::DEV_CODE)
                      && (shreg[see_pkg::CS_HI:see_pkg::CS_LO] == cs_s)
                      && !gate;
        end else begin
            byte_ok = !gate;
        end
    end

    assign commit = stop && (state == see_pkg::S_WDATA) && pend;
    assign xif.commit_tgl = tgl;

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_shreg  = shreg;
        next_rbyte  = rbyte;
        next_ptr    = ptr;
        next_ack    = ack;
        next_mack   = mack;
        next_oe_n   = oe_n;
        next_pend   = pend;
        next_tgl    = tgl;
        next_pvalid = pvalid;
        next_pbuf   = pbuf;
        next_hold   = hold && !busy_s;
        if (start) begin
            // Pending page is dropped, pointer kept
            next_state  = see_pkg::S_CTRL;
            next_cnt    = see_pkg::CNT_PRE;
            next_oe_n   = 1'b1;
            next_pend   = 1'b0;
            next_pvalid = see_pkg::PV_RST;
        end else if (stop) begin
            if (commit) begin
                next_tgl  = ~tgl;
                next_hold = 1'b1;
            end
            next_state  = see_pkg::S_IDLE;
            next_oe_n   = 1'b1;
            next_pend   = 1'b0;
            next_pvalid = see_pkg::PV_RST;
        end else if (state != see_pkg::S_IDLE) begin
            if (rise && cnt < see_pkg::CNT_ACK) begin
                next_shreg = {shreg[6:0], sda_s};
            end
            if (rise && cnt == see_pkg::CNT_ACK) begin
                next_mack = sda_s;
            end
            if (fall) begin
                if (cnt == see_pkg::CNT_PRE) begin
                    next_cnt = see_pkg::CNT_ZERO;
                end else if (state == see_pkg::S_RDATA) begin
                    if (cnt < see_pkg::CNT_LAST) begin
                        next_oe_n  = rbyte[7];
                        next_rbyte = {rbyte[6:0], 1'b0};
                        next_cnt   = cnt + 1'b1;
                    end else if (cnt == see_pkg::CNT_LAST) begin
                        next_oe_n = 1'b1;
                        next_cnt  = see_pkg::CNT_ACK;
                    end else if (!mack) begin
                        next_oe_n  = mem[ptr][7];
                        next_rbyte = {mem[ptr][6:0], 1'b0};
                        next_ptr   = ptr + 1'b1;
                        next_cnt   = see_pkg::CNT_ZERO;
                    end else begin
                        next_oe_n  = 1'b1;
                        next_state = see_pkg::S_IDLE;
                    end
                end else if (cnt < see_pkg::CNT_LAST) begin
                    next_cnt = cnt + 1'b1;
                end else if (cnt == see_pkg::CNT_LAST) begin
                    next_cnt  = see_pkg::CNT_ACK;
                    next_ack  = byte_ok;
                    next_oe_n = ~byte_ok;
                    if (byte_ok && state == see_pkg::S_ADDR) begin
                        next_ptr = shreg;
                    end
                    if (byte_ok && state == see_pkg::S_WDATA) begin
                        next_pbuf[ptr[PW-1:0]]   = shreg;
                        next_pvalid[ptr[PW-1:0]] = 1'b1;
                        next_ptr = {ptr[AW-1:PW],
                                    ptr[PW-1:0] + 1'b1};
                        next_pend = 1'b1;
                    end
                end else begin
                    next_cnt  = see_pkg::CNT_ZERO;
                    next_oe_n = 1'b1;
                    if (!ack) begin
                        next_state = see_pkg::S_IDLE;
                    end else if (state == see_pkg::S_CTRL) begin
                        if (shreg[see_pkg::RW_POS]) begin
                            next_state = see_pkg::S_RDATA;
                            next_oe_n  = mem[ptr][7];
                            next_rbyte = {mem[ptr][6:0], 1'b0};
                            next_ptr   = ptr + 1'b1;
                        end else begin
                            next_state = see_pkg::S_ADDR;
                        end
                    end else if (state == see_pkg::S_ADDR) begin
                        next_state = see_pkg::S_WDATA;
                    end
                end
            end
        end
    end

    // With wp low, every buffered byte of the page lands at once; the busy time follows from the timer
    always_comb begin
        next_mem = mem;
        if (commit && !wp_s) begin
            for (int i = 0; i < PL; i++) begin
                if (pvalid[i]) begin
                    next_mem[{ptr[AW-1:PW], PW'(i)}] = pbuf[i];
                end
            end
        end
    end

    always_ff @(posedge lclk) begin
        mem  <= next_mem;
        pbuf <= next_pbuf;
    end

    always_ff @(posedge lclk) begin
        if (lrst) begin
            state    <= see_pkg::S_IDLE;
            cnt      <= see_pkg::CNT_ZERO;
            shreg    <= '0;
            rbyte    <= '0;
            ptr      <= see_pkg::PTR_RST;
            ack      <= 1'b0;
            mack     <= 1'b1;
            oe_n     <= see_pkg::OE_N_RST;
            sda_oe_n <= see_pkg::OE_N_RST;
            sda_out  <= see_pkg::OUT_RST;
            pend     <= 1'b0;
            hold     <= 1'b0;
            tgl      <= 1'b0;
            pvalid   <= see_pkg::PV_RST;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            shreg    <= next_shreg;
            rbyte    <= next_rbyte;
            ptr      <= next_ptr;
            ack      <= next_ack;
            mack     <= next_mack;
            oe_n     <= next_oe_n;
            sda_oe_n <= next_oe_n;
            sda_out  <= see_pkg::OUT_RST;
            pend     <= next_pend;
            hold     <= next_hold;
            tgl      <= next_tgl;
            pvalid   <= next_pvalid;
            scl_d    <= scl_s;
            sda_d    <= sda_s;
        end
    end

    default clocking cb @(posedge lclk); endclocking
    default disable iff (lrst);

    ctrl_match_a: assert property (
        (state == see_pkg::S_CTRL && fall && cnt == see_pkg::CNT_LAST
         && shreg[7:4] != see_pkg::DEV_CODE) |=> ##1 sda_oe_n)
        else $error("foreign control byte acknowledged");
    busy_noack_a: assert property (
        (state == see_pkg::S_CTRL && cnt == see_pkg::CNT_ACK && gate)
        |=> sda_oe_n)
        else $error("acknowledge driven while busy");
    addr_load_a: assert property (
        (state == see_pkg::S_ADDR && fall && cnt == see_pkg::CNT_LAST
         && !gate) |=> ptr == $past(shreg))
        else $error("word address not loaded");
    low_incr_a: assert property (
        (state == see_pkg::S_WDATA && fall && cnt == see_pkg::CNT_LAST
         && !gate) |=> ptr[7:4] == $past(ptr[7:4])
                   && ptr[3:0] == $past(ptr[3:0]) + 4'h1)
        else $error("pointer upper bits moved in write");
    wp_keep_a: assert property (
        (commit && wp_s) |=> mem[{$past(ptr[7:4]), $past(ptr[3:0]) - 4'h1}]
                             == $past(mem[{ptr[7:4], ptr[3:0] - 4'h1}]))
        else $error("memory changed while protected");
    read_next_a: assert property (
        (state == see_pkg::S_RDATA && fall && cnt == see_pkg::CNT_ACK
         && !mack && !start && !stop) |=> ptr == $past(ptr) + 8'h01)
        else $error("pointer not advanced on read");
    nack_release_a: assert property (
        (state == see_pkg::S_RDATA && fall && cnt == see_pkg::CNT_ACK
         && mack && !start && !stop) |=> sda_oe_n && state == see_pkg::S_IDLE)
        else $error("data line held after no acknowledge");
    rstart_drop_a: assert property (
        (start && state == see_pkg::S_WDATA) |=> !pend && tgl == $past(tgl))
        else $error("repeated start began a write cycle");
    stop_commit_a: assert property (
        commit |=> tgl != $past(tgl) && hold)
        else $error("stop did not start write cycle");

endmodule

// ---- include/see_pkg.sv ----
package see_pkg;

    // Array and page geometry
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned PAGE_W   = 4;
    localparam int unsigned PAGE_LEN = 16;

    // Control byte layout
    localparam logic [3:0]  DEV_CODE = 4'ha;
    localparam int unsigned CODE_HI  = 7;
    localparam int unsigned CODE_LO  = 4;
    localparam int unsigned CS_HI    = 3;
    localparam int unsigned CS_LO    = 1;
    localparam int unsigned RW_POS   = 0;

    // Bit counter landmarks within one nine-clock byte frame
    localparam logic [3:0]  CNT_ZERO = 4'h0;
    localparam logic [3:0]  CNT_LAST = 4'h7;
    localparam logic [3:0]  CNT_ACK  = 4'h8;
    // Start's own clock fall carries no bit
    localparam logic [3:0]  CNT_PRE  = 4'hf;

    // Values after reset
    localparam logic [ADDR_W-1:0]   PTR_RST  = 8'h00;
    localparam logic                OE_N_RST = 1'b1;
    localparam logic                OUT_RST  = 1'b0;
    localparam logic [PAGE_LEN-1:0] PV_RST   = 16'h0000;

    // Self-timed write cycle
    localparam int unsigned TWC_MS  = 10;
    localparam int unsigned MCLK_HZ = 25_000_000;
    localparam int unsigned TWC_CYC = (MCLK_HZ / 1000) * TWC_MS;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CTRL  = 3'b001,
        S_ADDR  = 3'b010,
        S_WDATA = 3'b011,
        S_RDATA = 3'b100
    } see_state_t;

endpackage

// ---- include/see_xif.sv ----
interface see_xif;
    logic commit_tgl;
    logic busy;

    modport link (
        output commit_tgl,
        input  busy
    );

    modport timer (
        input  commit_tgl,
        output busy
    );
endinterface

// ---- rtl/see_sync.sv ----
module see_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock
    input  wire logic         clk,
    // Level in, level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end

endmodule

// ---- rtl/see_wtimer.sv ----
module see_wtimer #(
    parameter int unsigned TWC_CYCLES = see_pkg::TWC_CYC
) (
    // System clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Crossing to link logic
    see_xif.timer     xif
);

    localparam int unsigned CW = $clog2(TWC_CYCLES + 1);

    logic          tgl_s;
    logic          tgl_d;
    logic          busy;
    logic [CW-1:0] cnt;
    logic          next_busy;
    logic [CW-1:0] next_cnt;
    logic          kick;

    see_sync #(.W(1)) u_tgl (
        .clk (mclk),
        .d   (xif.commit_tgl),
        .q   (tgl_s)
    );

    assign kick     = tgl_s ^ tgl_d;
    assign xif.busy = busy;

    // Runs off mclk only, so the busy time never needs bus clocks
    always_comb begin
        next_busy = busy;
        next_cnt  = cnt;
        if (kick) begin
            next_busy = 1'b1;
            next_cnt  = CW'(TWC_CYCLES - 1);
        end else if (busy) begin
            if (cnt == '0) begin
                next_busy = 1'b0;
            end else begin
                next_cnt = cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy  <= 1'b0;
            cnt   <= '0;
            tgl_d <= 1'b0;
        end else begin
            busy  <= next_busy;
            cnt   <= next_cnt;
            tgl_d <= tgl_s;
        end
    end

    busy_length_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(busy) |-> busy [*8])
        else $error("write cycle ended too early");

    busy_start_a: assert property (@(posedge mclk) disable iff (rst)
        kick |=> busy)
        else $error("commit did not start a write cycle");

endmodule

// ---- tb/see_bus_master.sv ----
module see_bus_master (
    // Pacing clock
    input  wire logic       clk,
    // Bus lines, sda_drv high means released
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_drv,
    // Received ack or byte
    output logic            obs_valid,
    output logic [7:0]      obs_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // One of three phases of a bit in clk cycles (a bit is 2 + 3Q), slow versus the link clock
    localparam int Q = 8;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        obs_valid = 1'b0;
        obs_data = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic report(input logic [7:0] v);
        obs_data = v;
        obs_valid = 1'b1;
        tick(1);
        obs_valid = 1'b0;
    endtask

    task automatic clock_bit(input logic b, output logic s);
        tick(2);
        sda_drv = b;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        s = sda;
        tick(Q);
        scl = 1'b0;
    endtask

    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_drv = 1'b0;
        tick(Q);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_drv = 1'b1;
        tick(Q);
    endtask

    task automatic wr_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        report({7'h00, s});
    endtask

    task automatic rd_byte(input logic last);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        // Ack asks for more; no ack ends the read
        clock_bit(last, s);
        report(d);
    endtask
endmodule

// ---- tb/see_top_tb_top.sv ----
module see_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Long enough that several polls land inside the busy time
    localparam int         TWC = 2000;
    localparam logic [7:0] ACK = 8'h00;
    localparam logic [7:0] NAK = 8'h01;

    logic       mclk = 1'b0;
    logic       lclk = 1'b0;
    logic       rst;
    logic       wp;
    logic [2:0] cs;
    logic       scl;
    logic       m_sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic       write_busy;
    logic       obs_valid;
    logic [7:0] obs_data;
    logic [7:0] exp_q[$];
    logic [7:0] mem[256];
    int         busy_cnt = 0;
    int         cycles = 0;
    int         fail_count = 0;
    int         comparisons = 0;
    wire logic  sda;

    // Open drain line with pull-up
    assign sda = (sda_oe_n ? 1'b1 : sda_out) & m_sda;

    always #20 mclk = ~mclk;
    // Its edges meet an mclk edge once every 60 ns
    always #15 lclk = ~lclk;

    see_top #(.TWC_CYCLES(TWC)) dut (
        .mclk(mclk), .rst(rst), .lclk(lclk), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
        .chip_select_bit2(cs[2]), .wp(wp), .write_busy(write_busy)
    );

    see_bus_master m (
        .clk(mclk), .sda(sda), .scl(scl), .sda_drv(m_sda),
        .obs_valid(obs_valid), .obs_data(obs_data)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        if (obs_valid === 1'b1) begin
            check({8'h00, obs_data}, exp_q.size() > 0 ?
                  {8'h00, exp_q.pop_front()} : 16'hxxxx);
        end
        if (write_busy === 1'b0 && busy_cnt != 0) begin
            check(16'(busy_cnt), 16'(TWC));
        end
        busy_cnt <= (write_busy === 1'b1) ? busy_cnt + 1 : 0;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            complete_run();
        end
    end

    function automatic logic [7:0] ctl(input logic rw);
        return {see_pkg::DEV_CODE, cs, rw};
    endfunction

    task automatic send(input logic [7:0] b, input logic [7:0] e);
        exp_q.push_back(e);
        m.wr_byte(b);
    endtask

    task automatic poll_done();
        repeat (40) begin
            if (write_busy === 1'b1) break;
            @(negedge mclk);
        end
        check({15'h0, write_busy}, 16'h0001);
        // Poll only while the remaining busy time outlasts a byte
        while (write_busy === 1'b1 && TWC - busy_cnt > 300) begin
            m.start();
            send(ctl(1'b0), NAK);
        end
        repeat (TWC) begin
            if (write_busy !== 1'b1) break;
            @(negedge mclk);
        end
        repeat (10) @(negedge mclk);
        m.start();
        send(ctl(1'b0), ACK);
        m.stop();
    endtask

    task automatic write_seq(input logic [7:0] addr, input int n);
        logic [7:0] d;
        m.start();
        send(ctl(1'b0), ACK);
        send(addr, ACK);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (wp !== 1'b1) begin
                mem[{addr[7:4], 4'(addr[3:0] + i)}] = d;
            end
            send(d, ACK);
        end
        m.stop();
        poll_done();
    endtask

    task automatic read_seq(input logic [7:0] addr, input logic set,
                            input int n);
        m.start();
        if (set) begin
            send(ctl(1'b0), ACK);
            send(addr, ACK);
            m.start();
        end
        send(ctl(1'b1), ACK);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[8'(addr + i)]);
            m.rd_byte(i == n - 1);
        end
        m.stop();
        check({15'h0, write_busy}, 16'h0000);
    endtask

    initial begin
        logic [7:0] c;
        rst = 1'b1;
        wp = 1'b0;
        void'($urandom(32'h54df));
        cs = 3'($urandom);
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (10) @(negedge mclk);
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? {4'hb, cs, 1'b0}
                         : {see_pkg::DEV_CODE, cs ^ 3'(i), 1'b0};
            m.start();
            send(c, NAK);
            send(8'h00, NAK);
            m.stop();
        end
        write_seq(8'h00, 1);
        // Crosses the page end on purpose
        write_seq({4'hf, 4'($urandom)}, 18);
        read_seq(8'hf0, 1'b1, 17);
        read_seq(8'hff, 1'b1, 1);
        read_seq(8'h00, 1'b0, 1);
        wp = 1'b1;
        write_seq(8'h00, 1);
        wp = 1'b0;
        read_seq(8'h00, 1'b1, 1);
        repeat (20) @(negedge mclk);
        check(16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule
